/* hw/ref_select_pkg.sv */
// Constants and types shared by the reference selector and its helpers
package ref_select_pkg;
  localparam int NUM_CHAN = 5;
  localparam int NUM_CFG = 6;
  localparam int ADDR_W = 8;
  localparam logic [2:0] IDX_STATUS = 3'h6;
  localparam logic [2:0] IDX_NONE = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Configuration word indices; byte address is four times the index
  localparam int REG_PRE_PRI = 0;
  localparam int REG_PRE_SEC = 1;
  localparam int REG_RATIO_LO = 2;
  localparam int REG_RATIO_HI = 3;
  localparam int REG_SEL = 5;

  // Field positions
  localparam int PREDIV_LSB = 0;
  localparam int RATIO_LO_LSB = 0;
  localparam int RATIO_HI_BIT = 0;
  localparam int SEL_LSB = 2;
  localparam int FAILSAFE_BIT = 11;
  localparam int SRC_X_BIT = 4;
  localparam int SRC_Y_BIT = 5;
  localparam int BUF_FIELD_LSB = 22;

  // Selector codes, written as bits 5,4,3,2
  localparam logic [3:0] SEL_MAN_PRI = 4'h9;
  localparam logic [3:0] SEL_MAN_SEC = 4'hA;
  localparam logic [3:0] SEL_MAN_AUX = 4'hC;
  localparam logic [3:0] SEL_AUTO2 = 4'hB;
  localparam logic [3:0] SEL_AUTO3 = 4'hF;
  localparam logic [3:0] SEL_PIN = 4'h3;

  localparam logic [1:0] PREDIV_OFF = 2'h0;
  localparam logic [1:0] PREDIV_DIV2 = 2'h1;
  localparam logic [1:0] PREDIV_DIV1 = 2'h2;
  localparam logic [1:0] PREDIV_RSVD = 2'h3;

  localparam logic [1:0] SRC_PRI = 2'h0;
  localparam logic [1:0] SRC_SEC = 2'h1;
  localparam logic [1:0] SRC_SEL = 2'h2;
  localparam logic [1:0] SRC_SYN = 2'h3;

  // Buffer pattern, written as bits 22..27 with bit 22 leftmost
  localparam logic [5:0] BUF_ECL = 6'h01;
  localparam logic [5:0] BUF_LVDS = 6'h17;
  localparam logic [5:0] BUF_HIZ = 6'h16;
  localparam logic [1:0] BUF_SE = 2'h0;
  localparam logic [1:0] PIN_HIZ = 2'h1;
  localparam logic [1:0] PIN_LOW = 2'h3;

  localparam logic [2:0] FAILBACK_EDGES = 3'h4;
  localparam int CLK_PERIOD_NS = 50;
  localparam int LOS_WINDOW_NS = 1000;
  localparam int LOS_WINDOW_CYC =
    (LOS_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [31:0] CFG_RESET [NUM_CFG] = '{
    32'h0680_0002, 32'h0680_0002, 32'h0680_0000,
    32'h0680_0000, 32'h0680_0000, 32'h0000_0024};

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_FAILOVER = 2'b01,
    ST_FAILBACK = 2'b10
  } sel_state_type;
endpackage

/* hw/ref_prediv.sv */
// Pre-divider for one reference path: off, divide by two, or pass
`timescale 1ns/1ps
module ref_prediv
  import ref_select_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ref_in,
  input wire logic [1:0] code,
  output logic div_out
);
  logic prev_ff;
  logic half_ff;
  logic rise;
  logic nxt_half;

  assign rise = ref_in & ~prev_ff;
  assign nxt_half = half_ff ^ rise;

  always_ff @(posedge clk) begin
    if (reset) begin
      prev_ff <= 1'b0;
      half_ff <= 1'b0;
    end else begin
      prev_ff <= ref_in;
      half_ff <= nxt_half;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div_out <= 1'b0;
    end else begin
      case (code)
        PREDIV_DIV1: div_out <= ref_in;
        PREDIV_DIV2: div_out <= nxt_half;
        default: div_out <= 1'b0;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_PREDIV_OFF: assert property (
    (code == PREDIV_OFF || code == PREDIV_RSVD) |=> !div_out)
    else $error("disconnected pre-divider path not low");
  AST_PREDIV_PASS: assert property (
    code == PREDIV_DIV1 |=> div_out == $past(ref_in))
    else $error("undivided path does not follow its input");
  AST_PREDIV_HALF: assert property (
    code == PREDIV_DIV2 ##1 (code == PREDIV_DIV2 && !rise)
      |=> div_out == $past(div_out))
    else $error("halved path changed without an input edge");
endmodule

/* hw/ref_loss_detect.sv */
// Loss-of-signal monitor for one reference, windowed on the system clock
`timescale 1ns/1ps
module ref_loss_detect
  import ref_select_pkg::*;
#(
  parameter int WINDOW = LOS_WINDOW_CYC
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic ref_in,
  output logic lost
);
  localparam int CW = $clog2(WINDOW + 1);
  logic prev_ff;
  logic [CW-1:0] cnt_ff;
  logic rise;

  if (WINDOW < 2) begin : g_bad
    $error("loss window must span at least two cycles");
  end

  assign rise = ref_in & ~prev_ff;

  // Lost from reset on: nothing counts as present before its first edge
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_ff <= 1'b0;
      cnt_ff <= '0;
      lost <= 1'b1;
    end else begin
      prev_ff <= ref_in;
      if (rise) begin
        cnt_ff <= '0;
        lost <= 1'b0;
      end else if (cnt_ff == CW'(WINDOW - 1)) begin
        lost <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_LOS_DECLARE: assert property (
    (cnt_ff == CW'(WINDOW - 1) && !rise) |=> lost)
    else $error("silent reference not declared lost");
  AST_LOS_CLEAR: assert property (
    rise |=> !lost && cnt_ff == '0)
    else $error("edge did not clear loss");
endmodule

/* hw/ref_priority_select_and_route.sv */
// Reference selection, fail-over, reference divider and output routing
// Functional notes
// - One bit enables input bias failsafe for all inputs when set.
// - Selector code 1001 forwards only the primary reference.
// - Selector code 1010 forwards only the secondary reference.
// - Selector code 1100 forwards only the auxiliary reference.
// - Code 1011 auto over primary then secondary; 1111 adds auxiliary.
// - Code 0011 lets the select pin choose primary or secondary.
// - On loss, switch to next priority input at its first rise.
// - Output held low while fail-over waits for the new rise.
// - Returned higher input must show four cycles before fail-back.
// - During fail-back output stays high until the next falling edge.
// - Primary pre-divider: 00 off, 01 halve, 10 pass, 11 reserved.
// - Secondary pre-divider uses the same coding as the primary.
// - Reference divider after the first stage divides by field plus one.
// - Channel source: 00 primary, 01 secondary, 10 selector, 11 PLL.
// - Each channel divider stage takes its multiplexer's clock; no channel divider here, the registered multiplexer output drives the buffer.
// - Configuration words zero to four each steer their own channel.
// - Buffer pattern picks emitter-coupled, LVDS, high-Z or single-ended.
// - Single-ended negative pin: drive, high-Z or forced low by mode.
// - Single-ended positive pin uses the same mode coding.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ref_priority_select_and_route
  import ref_select_pkg::*;
#(
  parameter int LOS_WINDOW = LOS_WINDOW_CYC
)(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PRIMARY_REFERENCE,
  input wire logic SECONDARY_REFERENCE,
  input wire logic AUX_REF,
  input wire logic PLL_OUTPUT_CLOCK,
  input wire logic REF_SELECT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic FAILSAFE_BIAS_EN,
  output logic SEL_CLK_OUT,
  output logic REF_DIV_OUT,
  output logic [NUM_CHAN-1:0] OUT_P,
  output logic [NUM_CHAN-1:0] OUT_N,
  output logic [NUM_CHAN-1:0] OUT_P_OE_N,
  output logic [NUM_CHAN-1:0] OUT_N_OE_N
);
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    if (a[1:0] != 2'h0 || a[ADDR_W-1:5] != '0 || a[4:2] == IDX_NONE) begin
      return IDX_NONE;
    end
    return a[4:2];
  endfunction

  // Returns {level, output enable low}
  function automatic logic [1:0] pin_drive(input logic [1:0] m,
                                           input logic c);
    case (m)
      PIN_HIZ: return 2'b01;
      PIN_LOW: return 2'b00;
      default: return {c, 1'b0};
    endcase
  endfunction

  function automatic logic [5:0] buf_pattern(input logic [31:0] w);
    logic [5:0] p;
    for (int i = 0; i < 6; i++) begin
      p[5-i] = w[BUF_FIELD_LSB+i];
    end
    return p;
  endfunction

  logic [31:0] cfg_ff [NUM_CFG];
  logic [2:0] src_sig;
  logic [2:0] src_prev_ff;
  logic [2:0] lost;
  logic [2:0] src_rise;
  logic [2:0] src_fall;
  logic [3:0] sel_mode;
  logic auto_mode;
  logic [1:0] last_src;
  logic [1:0] best;
  logic best_ok;
  sel_state_type state_ff;
  logic [1:0] cur_ff;
  logic [1:0] tgt_ff;
  logic [2:0] ret_cnt_ff;
  logic sel_prev_ff;
  logic [2:0] ratio_m1;
  logic [2:0] div_cnt_ff;
  logic [NUM_CHAN-1:0] chan_clk_ff;
  logic [5:0] bt [NUM_CHAN];
  logic aw_have_ff;
  logic w_have_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic wr_go;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;

  // Reference paths: primary and secondary through their pre-dividers
  ref_prediv u_pre_pri (
    .clk(CLK), .reset(RESET), .ref_in(PRIMARY_REFERENCE),
    .code(cfg_ff[REG_PRE_PRI][PREDIV_LSB+:2]), .div_out(src_sig[0]));
  ref_prediv u_pre_sec (
    .clk(CLK), .reset(RESET), .ref_in(SECONDARY_REFERENCE),
    .code(cfg_ff[REG_PRE_SEC][PREDIV_LSB+:2]), .div_out(src_sig[1]));
  assign src_sig[2] = AUX_REF;

  for (genvar i = 0; i < 3; i++) begin : g_los
    ref_loss_detect #(.WINDOW(LOS_WINDOW)) u_los (
      .clk(CLK), .reset(RESET), .ref_in(src_sig[i]), .lost(lost[i]));
  end

  assign src_rise = src_sig & ~src_prev_ff;
  assign src_fall = ~src_sig & src_prev_ff;
  assign sel_mode = cfg_ff[REG_SEL][SEL_LSB+:4];
  assign auto_mode = sel_mode == SEL_AUTO2 || sel_mode == SEL_AUTO3;
  assign last_src = (sel_mode == SEL_AUTO3) ? 2'h2 : 2'h1;

  // Highest-priority input that is present within the active order
  always_comb begin
    best = cur_ff;
    best_ok = 1'b0;
    for (int i = 2; i >= 0; i--) begin
      if (2'(i) <= last_src && !lost[i]) begin
        best = 2'(i);
        best_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      src_prev_ff <= 3'h0;
      sel_prev_ff <= 1'b0;
    end else begin
      src_prev_ff <= src_sig;
      sel_prev_ff <= SEL_CLK_OUT;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_ff <= ST_HOLD;
      cur_ff <= 2'h0;
      tgt_ff <= 2'h0;
      ret_cnt_ff <= 3'h0;
    end else if (!auto_mode) begin
      state_ff <= ST_HOLD;
      cur_ff <= 2'h0;
      ret_cnt_ff <= 3'h0;
    end else begin
      case (state_ff)
        ST_HOLD: begin
          if (lost[cur_ff] && best_ok && best != cur_ff) begin
            state_ff <= ST_FAILOVER;
            tgt_ff <= best;
            ret_cnt_ff <= 3'h0;
          end else if (best_ok && best < cur_ff) begin
            if (tgt_ff != best) begin
              tgt_ff <= best;
              ret_cnt_ff <= 3'h0;
            end else if (ret_cnt_ff == FAILBACK_EDGES) begin
              state_ff <= ST_FAILBACK;
            end else if (src_rise[best]) begin
              ret_cnt_ff <= ret_cnt_ff + 3'h1;
            end
          end else begin
            ret_cnt_ff <= 3'h0;
          end
        end
        ST_FAILOVER: begin
          if (best_ok && tgt_ff != best) begin
            tgt_ff <= best;
          end else if (best_ok && src_rise[tgt_ff]) begin
            cur_ff <= tgt_ff;
            state_ff <= ST_HOLD;
          end
        end
        ST_FAILBACK: begin
          // A source lost mid fail-back leaves the old one in charge
          if (lost[tgt_ff]) begin
            state_ff <= ST_HOLD;
          end else if (src_fall[tgt_ff]) begin
            cur_ff <= tgt_ff;
            state_ff <= ST_HOLD;
            ret_cnt_ff <= 3'h0;
          end
        end
        default: state_ff <= ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      SEL_CLK_OUT <= 1'b0;
    end else begin
      case (sel_mode)
        SEL_MAN_PRI: SEL_CLK_OUT <= src_sig[0];
        SEL_MAN_SEC: SEL_CLK_OUT <= src_sig[1];
        SEL_MAN_AUX: SEL_CLK_OUT <= src_sig[2];
        SEL_PIN: SEL_CLK_OUT <= REF_SELECT ? src_sig[1] : src_sig[0];
        SEL_AUTO2, SEL_AUTO3: begin
          case (state_ff)
            ST_HOLD: SEL_CLK_OUT <= src_sig[cur_ff];
            ST_FAILOVER: SEL_CLK_OUT <= 1'b0;
            ST_FAILBACK: SEL_CLK_OUT <= 1'b1;
            default: SEL_CLK_OUT <= 1'b0;
          endcase
        end
        default: SEL_CLK_OUT <= 1'b0;
      endcase
    end
  end

  // Reference divider; odd ratios above one give an uneven duty cycle
  assign ratio_m1 = {cfg_ff[REG_RATIO_HI][RATIO_HI_BIT],
                     cfg_ff[REG_RATIO_LO][RATIO_LO_LSB+:2]};

  always_ff @(posedge CLK) begin
    if (RESET) begin
      div_cnt_ff <= 3'h0;
      REF_DIV_OUT <= 1'b0;
    end else begin
      if (SEL_CLK_OUT && !sel_prev_ff) begin
        div_cnt_ff <= (div_cnt_ff >= ratio_m1) ? 3'h0 : div_cnt_ff + 3'h1;
      end
      if (ratio_m1 == 3'h0) begin
        REF_DIV_OUT <= SEL_CLK_OUT;
      end else begin
        REF_DIV_OUT <= {1'b0, div_cnt_ff} < ({1'b0, ratio_m1} + 4'h2) >> 1;
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      bt[c] = buf_pattern(cfg_ff[c]);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      chan_clk_ff <= '0;
      OUT_P <= '0;
      OUT_N <= '0;
      OUT_P_OE_N <= '1;
      OUT_N_OE_N <= '1;
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        case ({cfg_ff[c][SRC_X_BIT], cfg_ff[c][SRC_Y_BIT]})
          SRC_PRI: chan_clk_ff[c] <= PRIMARY_REFERENCE;
          SRC_SEC: chan_clk_ff[c] <= SECONDARY_REFERENCE;
          SRC_SEL: chan_clk_ff[c] <= SEL_CLK_OUT;
          default: chan_clk_ff[c] <= PLL_OUTPUT_CLOCK;
        endcase
        if (bt[c] == BUF_ECL || bt[c] == BUF_LVDS) begin
          OUT_P[c] <= chan_clk_ff[c];
          OUT_N[c] <= ~chan_clk_ff[c];
          OUT_P_OE_N[c] <= 1'b0;
          OUT_N_OE_N[c] <= 1'b0;
        end else if (bt[c][1:0] == BUF_SE) begin
          {OUT_P[c], OUT_P_OE_N[c]} <=
            pin_drive(bt[c][5:4], chan_clk_ff[c]);
          {OUT_N[c], OUT_N_OE_N[c]} <=
            pin_drive(bt[c][3:2], chan_clk_ff[c]);
        end else begin
          OUT_P[c] <= 1'b0;
          OUT_N[c] <= 1'b0;
          OUT_P_OE_N[c] <= 1'b1;
          OUT_N_OE_N[c] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      FAILSAFE_BIAS_EN <= 1'b0;
    end else begin
      FAILSAFE_BIAS_EN <= cfg_ff[REG_SEL][FAILSAFE_BIT];
    end
  end

  // Bus write path: address and data may arrive in either order
  assign wr_go = aw_have_ff && w_have_ff && !BVALID;
  assign wr_idx = reg_index(aw_addr_ff);
  assign rd_idx = reg_index(ARADDR);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_have_ff <= 1'b1;
        w_data_ff <= WDATA;
        w_strb_ff <= WSTRB;
        WREADY <= 1'b0;
      end
      if (wr_go) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int r = 0; r < NUM_CFG; r++) begin
        cfg_ff[r] <= CFG_RESET[r];
      end
    end else if (wr_go && wr_idx < 3'(NUM_CFG)) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_ff[b]) begin
          cfg_ff[wr_idx][8*b+:8] <= w_data_ff[8*b+:8];
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= RESP_OKAY;
    end else begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RRESP <= (rd_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
        if (rd_idx < 3'(NUM_CFG)) begin
          RDATA <= cfg_ff[rd_idx];
        end else if (rd_idx == IDX_STATUS) begin
          RDATA <= {21'h0, SEL_CLK_OUT, ret_cnt_ff, state_ff, cur_ff, lost};
        end else begin
          RDATA <= 32'h0;
        end
      end
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_FAILSAFE: assert property (
    ##1 FAILSAFE_BIAS_EN == $past(cfg_ff[REG_SEL][FAILSAFE_BIT]))
    else $error("failsafe enable does not follow its bit");
  AST_MAN_PRI: assert property (
    sel_mode == SEL_MAN_PRI |=> SEL_CLK_OUT == $past(src_sig[0]))
    else $error("manual primary not forwarded");
  AST_MAN_SEC: assert property (
    sel_mode == SEL_MAN_SEC |=> SEL_CLK_OUT == $past(src_sig[1]))
    else $error("manual secondary not forwarded");
  AST_MAN_AUX: assert property (
    sel_mode == SEL_MAN_AUX |=> SEL_CLK_OUT == $past(src_sig[2]))
    else $error("manual auxiliary not forwarded");
  AST_PIN_SEL: assert property (
    sel_mode == SEL_PIN && REF_SELECT |=> SEL_CLK_OUT == $past(src_sig[1]))
    else $error("select pin high did not forward secondary");
  AST_FAILOVER_EDGE: assert property (
    (state_ff == ST_FAILOVER && best_ok && tgt_ff == best
      && src_rise[tgt_ff]) |=> state_ff == ST_HOLD
      && cur_ff == $past(tgt_ff))
    else $error("fail-over did not complete on first rise");
  AST_FAILOVER_LOW: assert property (
    auto_mode && state_ff == ST_FAILOVER |=> !SEL_CLK_OUT)
    else $error("selector output not low during fail-over");
  AST_FAILBACK_COUNT: assert property (
    $rose(state_ff == ST_FAILBACK) |-> $past(ret_cnt_ff) == FAILBACK_EDGES)
    else $error("fail-back entered before four cycles");
  AST_FAILBACK_HIGH: assert property (
    auto_mode && state_ff == ST_FAILBACK |=> SEL_CLK_OUT)
    else $error("selector output not high during fail-back");
  AST_REF_DIV_WRAP: assert property (
    (SEL_CLK_OUT && !sel_prev_ff && div_cnt_ff >= ratio_m1)
      |=> div_cnt_ff == 3'h0)
    else $error("reference divider did not wrap at ratio");
  AST_UNLISTED_LOW: assert property (
    !auto_mode && sel_mode != SEL_MAN_PRI && sel_mode != SEL_MAN_SEC
      && sel_mode != SEL_MAN_AUX && sel_mode != SEL_PIN |=> !SEL_CLK_OUT)
    else $error("unlisted selector code not held low");

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chk
    AST_CHAN_PLL_OUTPUT_CLOCK: assert property (
      ({cfg_ff[c][SRC_X_BIT], cfg_ff[c][SRC_Y_BIT]} == SRC_SYN
        && bt[c] == BUF_ECL) ##1 bt[c] == BUF_ECL
        |=> OUT_P[c] == $past(PLL_OUTPUT_CLOCK, 2) && !OUT_P_OE_N[c])
      else $error("channel does not carry its chosen clock");
    AST_CHAN_HIZ: assert property (
      bt[c] == BUF_HIZ |=> OUT_P_OE_N[c] && OUT_N_OE_N[c])
      else $error("disabled channel still drives");
    AST_NEG_LOW: assert property (
      bt[c][1:0] == BUF_SE && bt[c][3:2] == PIN_LOW
        |=> !OUT_N[c] && !OUT_N_OE_N[c])
      else $error("negative pin not forced low");
    AST_POS_HIZ: assert property (
      bt[c][1:0] == BUF_SE && bt[c][5:4] == PIN_HIZ |=> OUT_P_OE_N[c])
      else $error("positive pin not released");
  end

  COV_FAILOVER: cover property (
    state_ff == ST_FAILOVER ##[1:200] state_ff == ST_HOLD);
  COV_FAILBACK: cover property (
    state_ff == ST_FAILBACK ##[1:200] state_ff == ST_HOLD);
  COV_AUX_AUTO: cover property (sel_mode == SEL_AUTO3 && cur_ff == 2'h2);
  COV_PIN_SEC: cover property (sel_mode == SEL_PIN && REF_SELECT);
endmodule

/* tb/ref_source.sv */
// Reference clock source model, stepped off the falling system edge
`timescale 1ns/1ps
module ref_source #(parameter int HALF = 3) (
  input wire logic clk,
  input wire logic run,
  output logic ref_o
);
  int cnt = 0;
  initial ref_o = 1'b0;
  // A stopped source parks low, as a dead driver would
  always @(negedge clk) begin
    cnt <= (run && cnt < HALF - 1) ? cnt + 1 : 0;
    if (!run) ref_o <= 1'b0;
    else if (cnt == HALF - 1) ref_o <= ~ref_o;
  end
endmodule

/* tb/test_ref_priority_select_and_route.sv */
// Self-checking bench for the reference selector and output router
`timescale 1ns/1ps
module test_ref_priority_select_and_route;
  import ref_select_pkg::*;
  logic clk = 0, reset = 1, pin = 0, awv = 0, wv = 0, br = 0, arv = 0;
  logic rr = 0, awr, wrdy, bv, arr, rv, fs, sel, rdiv;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat;
  logic [3:0] ws = 0, run = 4'hF, refs;
  logic [1:0] bresp, rresp;
  logic [4:0] op, on, pe, ne;
  int miscompares = 0, n_compared = 0, rises [11];
  always #25 clk = ~clk;
  ref_source #(.HALF(3)) u0 (.clk(clk), .run(run[0]), .ref_o(refs[0]));
  ref_source #(.HALF(4)) u1 (.clk(clk), .run(run[1]), .ref_o(refs[1]));
  ref_source #(.HALF(5)) u2 (.clk(clk), .run(run[2]), .ref_o(refs[2]));
  ref_source #(.HALF(2)) u3 (.clk(clk), .run(run[3]), .ref_o(refs[3]));
  ref_priority_select_and_route #(.LOS_WINDOW(16)) dut (
    .CLK(clk), .RESET(reset), .PRIMARY_REFERENCE(refs[0]),
    .SECONDARY_REFERENCE(refs[1]), .AUX_REF(refs[2]),
    .PLL_OUTPUT_CLOCK(refs[3]), .REF_SELECT(pin),
    .AWVALID(awv), .AWREADY(awr), .AWADDR(awa), .WVALID(wv),
    .WREADY(wrdy), .WDATA(wd), .WSTRB(ws), .BVALID(bv), .BREADY(br),
    .BRESP(bresp), .ARVALID(arv), .ARREADY(arr), .ARADDR(ara),
    .RVALID(rv), .RREADY(rr), .RDATA(rdat), .RRESP(rresp),
    .FAILSAFE_BIAS_EN(fs), .SEL_CLK_OUT(sel), .REF_DIV_OUT(rdiv),
    .OUT_P(op), .OUT_N(on), .OUT_P_OE_N(pe), .OUT_N_OE_N(ne));
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Edge counts near a window boundary may be off by one
  function automatic logic [31:0] nr(input int a, b);
    return (a >= b - 1 && a <= b + 1) ? b : a;
  endfunction
  function automatic logic [31:0] cw(input logic [1:0] s, logic [5:0] b);
    logic [31:0] w;
    w = 32'h0000_0002;
    w[4] = s[1];
    w[5] = s[0];
    for (int i = 0; i < 6; i++) w[22+i] = b[5-i];
    return w;
  endfunction
  task automatic wr(input logic [7:0] a, logic [31:0] d,
                    logic [1:0] er = RESP_OKAY);
    logic aw, w;
    @(posedge clk);
    {awv, wv, br} <= 3'h7;
    awa <= a;
    wd <= d;
    ws <= 4'hF;
    aw = 0;
    w = 0;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && awr === 1'b1) begin aw = 1; awv <= 0; end
      if (!w && wrdy === 1'b1) begin w = 1; wv <= 0; end
    end
    do @(posedge clk); while (bv !== 1'b1);
    br <= 0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    arv <= 1;
    ara <= a;
    rr <= 1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clk); while (rv !== 1'b1);
    rr <= 0;
    d = rdat;
    r = rresp;
  endtask
  task automatic mode(input logic [3:0] c);
    wr(8'h14, {26'h0, c, 2'h0});
  endtask
  task automatic measure(input int n);
    logic [10:0] p, c;
    repeat (4) @(negedge clk);
    p = {op, rdiv, sel, refs};
    rises = '{default: 0};
    repeat (n) begin
      @(negedge clk);
      c = {op, rdiv, sel, refs};
      for (int i = 0; i < 11; i++) if (c[i] && !p[i]) rises[i]++;
      p = c;
    end
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    chk({pe, ne}, 10'h3FF);
    rd(8'h14, d, r);
    chk(d, 32'h0000_0024);
    rd(8'h00, d, r);
    chk(d, 32'h0680_0002);
    rd(8'h40, d, r);
    chk(r, RESP_SLVERR);
    wr(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h0000_0824);
    repeat (3) @(negedge clk);
    chk(fs, 1'b1);
    mode(SEL_MAN_PRI);
    repeat (3) @(negedge clk);
    chk(fs, 1'b0);
  endtask
  task automatic t_manual;
    logic [3:0] cs [5] = '{SEL_MAN_PRI, SEL_MAN_SEC, SEL_MAN_AUX,
                           SEL_PIN, SEL_PIN};
    int s [5] = '{0, 1, 2, 0, 1};
    for (int i = 0; i < 5; i++) begin
      mode(cs[i]);
      pin <= (i == 4);
      run <= 4'h8 | (4'h1 << s[i]);
      measure(60);
      chk(nr(rises[4], rises[s[i]]), rises[s[i]]);
      run <= 4'hF & ~(4'h1 << s[i]);
      measure(60);
      chk(rises[4], 0);
    end
    mode(4'h0);
    run <= 4'hF;
    measure(60);
    chk(rises[4], 0);
  endtask
  task automatic t_div;
    logic [1:0] cs [3] = '{PREDIV_OFF, PREDIV_DIV2, PREDIV_RSVD};
    int q [3] = '{1, 3, 8};
    int e;
    for (int p = 0; p < 2; p++) begin
      mode(p ? SEL_MAN_SEC : SEL_MAN_PRI);
      for (int i = 0; i < 3; i++) begin
        wr(8'(p * 4), {30'h01A0_0000, cs[i]});
        measure(96);
        e = (i == 1) ? rises[p] / 2 : 0;
        chk(nr(rises[4], e), e);
      end
      wr(8'(p * 4), 32'h0680_0002);
    end
    mode(SEL_MAN_PRI);
    for (int i = 0; i < 3; i++) begin
      wr(8'h08, {30'h01A0_0000, 2'(q[i] - 1)});
      wr(8'h0C, {31'h0340_0000, 1'((q[i] - 1) >> 2)});
      measure(120);
      e = rises[4] / q[i];
      chk(nr(rises[5], e), e);
    end
  endtask
  task automatic t_auto;
    logic [31:0] d;
    logic [1:0] r;
    mode(SEL_AUTO2);
    run <= 4'hE;
    repeat (40) @(negedge clk);
    rd(8'h18, d, r);
    chk(d[4:3], 2'h1);
    measure(48);
    chk(nr(rises[4], rises[1]), rises[1]);
    run <= 4'hF;
    repeat (12) @(negedge clk);
    rd(8'h18, d, r);
    chk(d[4:3], 2'h1);
    repeat (50) @(negedge clk);
    rd(8'h18, d, r);
    chk(d[4:3], 2'h0);
    mode(SEL_AUTO3);
    run <= 4'hC;
    repeat (60) @(negedge clk);
    rd(8'h18, d, r);
    chk(d[4:3], 2'h2);
  endtask
  task automatic t_route;
    mode(SEL_MAN_SEC);
    wr(8'h00, cw(SRC_SEC, BUF_LVDS));
    wr(8'h04, cw(SRC_SYN, BUF_ECL));
    wr(8'h08, cw(SRC_SEL, BUF_LVDS));
    wr(8'h0C, cw(SRC_PRI, BUF_HIZ));
    wr(8'h10, cw(SRC_PRI, 6'h0C));
    run <= 4'hA;
    measure(60);
    chk(nr(rises[6], rises[1]), rises[1]);
    chk(nr(rises[7], rises[3]), rises[3]);
    chk(nr(rises[8], rises[1]), rises[1]);
    chk(rises[10], 0);
    chk({pe, ne}, 10'h108);
    chk(op[0] ^ on[0], 1'b1);
    run <= 4'hF;
    measure(60);
    chk(nr(rises[10], rises[0]), rises[0]);
    chk(on[4], 1'b0);
    wr(8'h10, cw(SRC_PRI, 6'h18));
    repeat (4) @(negedge clk);
    chk({pe[4], ne[4]}, 2'h2);
    wr(8'h10, cw(SRC_PRI, 6'h30));
    repeat (4) @(negedge clk);
    chk({op[4], pe[4], ne[4]}, 3'h0);
  endtask
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    t_reset();
    t_manual();
    t_div();
    t_auto();
    t_route();
    stop_test();
  end
  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end
endmodule
